// ---- logic/ldrs_core.sv ----
/*
  Display RAM scan core: host byte path into display RAM, column and
  common re-mapping, start-line scrolling, output latch and level select.
  Assumes the host port delivers one byte per strobe with data/command
  select already sampled, and that command fields arrive pre-decoded.
*/
// Functional notes
// - Software selects bias 1/4, 1/5, 1/6, 1/7, 1/8 or 1/9.
// - Four temperature compensation settings, first one after reset.
// - Display RAM is 132 columns by 65 rows, one bit per pixel.
// - Segment and common outputs can both be re-mapped by software.
// - Start line register picks the RAM row on the first common.
// - Rows outside the active commons stay host readable and writable.
// - Reset pin and power-on reset load the same settings; only power-on reset also clears scanner, latch, levels and read data.
// - After reset panel off; read-modify-write, static, test off.
// - After reset multiplex is the full common count plus icon line.
// - After reset column mapping is normal, column 00h on segment 0.
// - After reset power control is 000b, all supply enables off.
// - Reset clears the serial input shift register.
// - After reset bias is the variant default.
// - After reset start line and page address are zero.
// - After reset column address counter is 00h.
// - After reset common scan is normal direction.
// - After reset contrast setting is 20h.
// - Output latch holds one bit per segment, common and icon.
// - Latch shifts on frame shift clock; levels follow phase signal.
// - Levels split in two sets, each used in a different phase.
// - Data/command high writes RAM, low means command.
// - Reversed common scan drives lines N-1 down to 0.
// - Read-modify-write mode stops column increment on reads.
`timescale 1ns/1ps
`default_nettype none
module ldrs_core (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire logic         hw_reset_n_pin_in,
  input  wire logic         byte_valid_in,
  input  wire logic         byte_is_data_in,
  input  wire logic [7:0]   byte_in,
  input  wire logic         data_read_in,
  input  wire logic         ser_clk_in,
  input  wire logic         ser_data_in,
  input  wire logic         cmd_col_lo_in,
  input  wire logic         cmd_col_hi_in,
  input  wire logic         cmd_page_in,
  input  wire logic         cmd_start_in,
  input  wire logic         cmd_contrast_in,
  input  wire logic         cmd_power_in,
  input  wire logic         cmd_bias_in,
  input  wire logic         cmd_temp_in,
  input  wire logic         cmd_mux_in,
  input  wire logic         cmd_seg_remap_in,
  input  wire logic         cmd_com_rev_in,
  input  wire logic         cmd_display_in,
  input  wire logic         cmd_rmw_in,
  input  wire logic         cmd_rmw_end_in,
  input  wire logic         cmd_static_in,
  input  wire logic         cmd_test_in,
  output logic [7:0]        rd_data_out,
  output logic [7:0]        col_addr_out,
  output logic [3:0]        page_addr_out,
  output logic [5:0]        start_line_out,
  output logic [5:0]        contrast_out,
  output logic [2:0]        power_ctrl_out,
  output logic [2:0]        bias_out,
  output logic [1:0]        temp_comp_out,
  output logic [6:0]        mux_out,
  output logic              seg_remap_out,
  output logic              com_rev_out,
  output logic              display_on_out,
  output logic              rmw_out,
  output logic              static_on_out,
  output logic              test_on_out,
  output logic [7:0]        ser_shift_out,
  output logic              frame_shift_clock_out,
  output logic              phase_out,
  output logic [196:0]      latch_out,
  output logic [196:0]      level_set_out
);
  ldrs_ram_if ram_bus ();

  logic [1:0]   rst_pin_sync_q;
  logic         int_rst;
  logic [1:0]   sck_sync_q;
  logic [1:0]   sda_sync_q;
  logic         sck_prev_q;
  logic [7:0]   col_q;
  logic [3:0]   page_q;
  logic [5:0]   start_q;
  logic [5:0]   contrast_q;
  logic [2:0]   power_q;
  logic [2:0]   bias_q;
  logic [1:0]   temp_q;
  logic [6:0]   mux_q;
  logic         seg_remap_q;
  logic         com_rev_q;
  logic         disp_q;
  logic         rmw_q;
  logic         static_q;
  logic         test_q;
  logic [7:0]   shift_q;
  logic [7:0]   rd_q;
  logic [196:0] latch_q;
  logic [196:0] level_q;
  logic         fsc_q;
  logic         phase_q;
  logic         scan_tick;
  logic [6:0]   scan_line;
  logic         scan_phase;
  logic         wr_data_byte;
  logic [6:0]   com_idx;
  logic [131:0] seg_bits;

  // Column step with wrap at the last column
  function automatic logic [7:0] next_col(input logic [7:0] c);
    return (c == ldrs_pkg::LAST_COL) ? ldrs_pkg::COL_RST : c + 8'h01;
  endfunction

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_pin_sync_q <= 2'b11;
    end else begin
      rst_pin_sync_q <= {rst_pin_sync_q[0], hw_reset_n_pin_in};
    end
  end
  // A pin pulse shorter than one cycle may be missed; the host holds it 1 us
  // Pulse long enough
  assign int_rst = ~rst_pin_sync_q[1];

  ldrs_scan u_scan (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .mux_in     (mux_q),
    .shift_out  (scan_tick),
    .line_out   (scan_line),
    .phase_out  (scan_phase)
  );

  ldrs_ram u_ram (
    .ref_clk_in (ref_clk_in),
    .bus        (ram_bus.ram)
  );

  assign wr_data_byte      = byte_valid_in & byte_is_data_in;
  assign ram_bus.wr_en     = wr_data_byte & ~int_rst;
  assign ram_bus.wr_col    = col_q;
  assign ram_bus.wr_page   = page_q;
  assign ram_bus.wr_data   = byte_in;
  assign ram_bus.rd_col    = col_q;
  assign ram_bus.rd_page   = page_q;

  assign com_idx = (scan_line == mux_q) ? scan_line :
                   (com_rev_q ? mux_q - 7'h01 - scan_line : scan_line);
  assign ram_bus.scan_row = (scan_line == mux_q) ? ldrs_pkg::ICON_ROW :
                            {1'b0, 6'(start_q + scan_line[5:0])};
  always_comb begin
    for (int s = 0; s < ldrs_pkg::NUM_COLS; s++) begin
      seg_bits[s] = seg_remap_q ? ram_bus.scan_bits[ldrs_pkg::NUM_COLS-1-s]
                                : ram_bus.scan_bits[s];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_sync_q <= 2'b00;
      sda_sync_q <= 2'b00;
      sck_prev_q <= 1'b0;
      shift_q    <= 8'h00;
    end else begin
      sck_sync_q <= {sck_sync_q[0], ser_clk_in};
      sda_sync_q <= {sda_sync_q[0], ser_data_in};
      sck_prev_q <= sck_sync_q[1];
      if (int_rst) begin
        shift_q <= 8'h00;
      end else if (sck_sync_q[1] & ~sck_prev_q) begin
        shift_q <= {shift_q[6:0], sda_sync_q[1]};
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      col_q <= ldrs_pkg::COL_RST;
    end else if (int_rst) begin
      col_q <= ldrs_pkg::COL_RST;
    end else if (byte_valid_in & ~byte_is_data_in & cmd_col_lo_in) begin
      col_q <= {col_q[7:4], byte_in[3:0]};
    end else if (byte_valid_in & ~byte_is_data_in & cmd_col_hi_in) begin
      col_q <= {byte_in[3:0], col_q[3:0]};
    end else if (wr_data_byte) begin
      col_q <= next_col(col_q);
    end else if (data_read_in & ~rmw_q) begin
      col_q <= next_col(col_q);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= 8'h00;
    end else if (data_read_in) begin
      rd_q <= ram_bus.rd_data;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_q  <= ldrs_pkg::PAGE_RST;
      start_q <= ldrs_pkg::START_RST;
    end else if (int_rst) begin
      page_q  <= ldrs_pkg::PAGE_RST;
      start_q <= ldrs_pkg::START_RST;
    end else if (byte_valid_in & ~byte_is_data_in) begin
      if (cmd_page_in && byte_in[3:0] <= ldrs_pkg::ICON_PAGE) begin
        page_q <= byte_in[3:0];
      end
      if (cmd_start_in) begin
        start_q <= byte_in[5:0];
      end
    end
  end

  // Settings: one block for the analogue-facing controls
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      contrast_q <= ldrs_pkg::CONTRAST_RST;
      power_q    <= ldrs_pkg::POWER_RST;
      bias_q     <= ldrs_pkg::BIAS_RST;
      temp_q     <= ldrs_pkg::TEMP_RST;
    end else if (int_rst) begin
      contrast_q <= ldrs_pkg::CONTRAST_RST;
      power_q    <= ldrs_pkg::POWER_RST;
      bias_q     <= ldrs_pkg::BIAS_RST;
      temp_q     <= ldrs_pkg::TEMP_RST;
    end else if (byte_valid_in & ~byte_is_data_in) begin
      if (cmd_contrast_in) begin
        contrast_q <= byte_in[5:0];
      end
      if (cmd_power_in) begin
        power_q <= byte_in[2:0];
      end
      if (cmd_bias_in && byte_in[2:0] <= 3'(ldrs_pkg::LDRS_BIAS_9)) begin
        bias_q <= byte_in[2:0];
      end
      if (cmd_temp_in) begin
        temp_q <= byte_in[1:0];
      end
    end
  end

  // Mode bits: mapping, scan direction and display modes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mux_q       <= ldrs_pkg::MUX_MAX;
      seg_remap_q <= 1'b0;
      com_rev_q   <= 1'b0;
      disp_q      <= 1'b0;
      rmw_q       <= 1'b0;
      static_q    <= 1'b0;
      test_q      <= 1'b0;
    end else if (int_rst) begin
      mux_q       <= ldrs_pkg::MUX_MAX;
      seg_remap_q <= 1'b0;
      com_rev_q   <= 1'b0;
      disp_q      <= 1'b0;
      rmw_q       <= 1'b0;
      static_q    <= 1'b0;
      test_q      <= 1'b0;
    end else if (byte_valid_in & ~byte_is_data_in) begin
      if (cmd_mux_in && byte_in[6:0] != 7'h00 &&
          byte_in[6:0] <= ldrs_pkg::MUX_MAX) begin
        mux_q <= byte_in[6:0];
      end
      if (cmd_seg_remap_in) begin
        seg_remap_q <= byte_in[0];
      end
      if (cmd_com_rev_in) begin
        com_rev_q <= byte_in[3];
      end
      if (cmd_display_in) begin
        disp_q <= byte_in[0];
      end
      if (cmd_rmw_in) begin
        rmw_q <= 1'b1;
      end else if (cmd_rmw_end_in) begin
        rmw_q <= 1'b0;
      end
      if (cmd_static_in) begin
        static_q <= byte_in[0];
      end
      if (cmd_test_in) begin
        test_q <= byte_in[0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_q <= '0;
      fsc_q   <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      fsc_q <= scan_tick;
      if (scan_tick) begin
        phase_q <= scan_phase;
        latch_q <= '0;
        latch_q[131:0] <= disp_q ? seg_bits : 132'h0;
        latch_q[132 + int'(com_idx)] <= disp_q;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= '0;
    end else if (fsc_q) begin
      level_q <= latch_q ^ {197{phase_q}};
    end
  end

  assign rd_data_out           = rd_q;
  assign col_addr_out          = col_q;
  assign page_addr_out         = page_q;
  assign start_line_out        = start_q;
  assign contrast_out          = contrast_q;
  assign power_ctrl_out        = power_q;
  assign bias_out              = bias_q;
  assign temp_comp_out         = temp_q;
  assign mux_out               = mux_q;
  assign seg_remap_out         = seg_remap_q;
  assign com_rev_out           = com_rev_q;
  assign display_on_out        = disp_q;
  assign rmw_out               = rmw_q;
  assign static_on_out         = static_q;
  assign test_on_out           = test_q;
  assign ser_shift_out         = shift_q;
  assign frame_shift_clock_out = fsc_q;
  assign phase_out             = phase_q;
  assign latch_out             = latch_q;
  assign level_set_out         = level_q;
endmodule
`default_nettype wire

// ---- logic/ldrs_pkg.sv ----
/*
  Package for the display RAM scan core: geometry, reset values, field
  widths and timing counts. Assumes a 100 MHz core clock.
*/
package ldrs_pkg;
  localparam int unsigned NUM_COLS      = 132;
  localparam int unsigned NUM_ROWS      = 65;
  localparam int unsigned NUM_PAGES     = 9;
  localparam int unsigned RAM_BITS      = NUM_COLS * NUM_ROWS;
  localparam int unsigned COL_W         = 8;
  localparam int unsigned ROW_W         = 7;
  localparam int unsigned PAGE_W        = 4;
  localparam logic [7:0]  LAST_COL      = 8'h83;
  localparam logic [6:0]  ICON_ROW      = 7'h40;
  localparam logic [3:0]  ICON_PAGE     = 4'h8;
  localparam logic [6:0]  MUX_MAX       = 7'h40;
  localparam logic [5:0]  START_RST     = 6'h00;
  localparam logic [3:0]  PAGE_RST      = 4'h0;
  localparam logic [7:0]  COL_RST       = 8'h00;
  localparam logic [5:0]  CONTRAST_RST  = 6'h20;
  localparam logic [2:0]  POWER_RST     = 3'h0;
  localparam logic [1:0]  TEMP_RST      = 2'h0;
  localparam int unsigned LATCH_BITS    = NUM_COLS + 65;
  // Line period of the frame shift clock, in core cycles
  localparam int unsigned LINE_NS       = 1000;
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned LINE_CYCLES   = LINE_NS / CLK_NS;
  localparam int unsigned LINE_CNT_W    = 7;
  // Bias ratio codes
  typedef enum logic [2:0] {
    LDRS_BIAS_4, LDRS_BIAS_5, LDRS_BIAS_6, LDRS_BIAS_7,
    LDRS_BIAS_8, LDRS_BIAS_9
  } ldrs_bias_e;
  localparam logic [2:0]  BIAS_RST      = 3'h5;
endpackage

// ---- logic/ldrs_ram_if.sv ----
/*
  Interface joining the scan core to its display RAM store.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface ldrs_ram_if;
  logic       wr_en;
  logic [7:0] wr_col;
  logic [3:0] wr_page;
  logic [7:0] wr_data;
  logic [7:0] rd_col;
  logic [3:0] rd_page;
  logic [7:0] rd_data;
  logic [6:0] scan_row;
  logic [131:0] scan_bits;
  modport core (output wr_en, wr_col, wr_page, wr_data, rd_col, rd_page,
                scan_row, input rd_data, scan_bits);
  modport ram  (input wr_en, wr_col, wr_page, wr_data, rd_col, rd_page,
                scan_row, output rd_data, scan_bits);
endinterface
`default_nettype wire

// ---- logic/ldrs_ram.sv ----
/*
  Display RAM: 132 columns by 65 rows of flip-flops, byte written by page.
  Assumes the core keeps page and column in range.
*/
`timescale 1ns/1ps
`default_nettype none
module ldrs_ram (
  input  wire logic ref_clk_in,
  ldrs_ram_if.ram   bus
);
  logic [131:0] mem_q [65];

  // Row index of bit b of a page
  function automatic int unsigned row_of(input logic [3:0] pg, input int b);
    return int'(pg) * 8 + b;
  endfunction

  // No reset on storage: contents are undefined at power up
  always_ff @(posedge ref_clk_in) begin
    if (bus.wr_en) begin
      for (int b = 0; b < 8; b++) begin
        if (row_of(bus.wr_page, b) < ldrs_pkg::NUM_ROWS) begin
          mem_q[row_of(bus.wr_page, b)][bus.wr_col] <= bus.wr_data[b];
        end
      end
    end
  end

  always_comb begin
    bus.rd_data = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if (row_of(bus.rd_page, b) < ldrs_pkg::NUM_ROWS) begin
        bus.rd_data[b] = mem_q[row_of(bus.rd_page, b)][bus.rd_col];
      end
    end
  end

  assign bus.scan_bits = mem_q[bus.scan_row];
endmodule
`default_nettype wire

// ---- logic/ldrs_scan.sv ----
/*
  Line scanner: counts lines of a frame, pulses the frame shift clock at
  each line and toggles the alternation phase each frame.
  Assumes the multiplex value is never zero.
*/
`timescale 1ns/1ps
`default_nettype none
module ldrs_scan (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [6:0] mux_in,
  output logic            shift_out,
  output logic [6:0]      line_out,
  output logic            phase_out
);
  logic [6:0] cyc_q;
  logic [6:0] line_q;
  logic       phase_q;
  logic       tick;

  assign tick      = (cyc_q == 7'(ldrs_pkg::LINE_CYCLES - 1));
  assign shift_out = tick;
  assign line_out  = line_q;
  assign phase_out = phase_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc_q <= 7'h00;
    end else begin
      cyc_q <= tick ? 7'h00 : cyc_q + 7'h01;
    end
  end

  // Line mux_in is the icon line, so a frame has mux_in + 1 lines
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      line_q  <= 7'h00;
      phase_q <= 1'b0;
    end else if (tick) begin
      if (line_q >= mux_in) begin
        line_q  <= 7'h00;
        phase_q <= ~phase_q;
      end else begin
        line_q <= line_q + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/ldrs_host_model.sv ----
/*
  Host side model: byte strobes, command qualifiers, reads, serial pins
  and the reset pin. Assumes callers enter each task just after a
  rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ldrs_host_model (
  input  wire logic  ref_clk_in,
  output logic       pin_n_out,
  output logic       valid_out,
  output logic       is_data_out,
  output logic [7:0] byte_out,
  output logic [15:0] cmd_out,
  output logic       read_out,
  output logic       sck_out,
  output logic       sda_out
);
  initial begin
    pin_n_out = 1'b1;
    valid_out = 1'b0;
    is_data_out = 1'b0;
    byte_out = 8'h00;
    cmd_out = 16'h0000;
    read_out = 1'b0;
    sck_out = 1'b0;
    sda_out = 1'b0;
  end
  task automatic put(input logic d, input int k, input logic [7:0] b);
    valid_out <= 1'b1;
    is_data_out <= d;
    byte_out <= b;
    cmd_out <= d ? 16'h0000 : 16'h0001 << k;
    @(posedge ref_clk_in);
    valid_out <= 1'b0;
    cmd_out <= 16'h0000;
    // Released bus shows the inverse, not a stale copy
    byte_out <= ~b;
    @(posedge ref_clk_in);
  endtask
  task automatic get();
    read_out <= 1'b1;
    @(posedge ref_clk_in);
    read_out <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic pin_reset();
    pin_n_out <= 1'b0;
    repeat (100) @(posedge ref_clk_in);
    pin_n_out <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_out <= b[i];
      repeat (3) @(posedge ref_clk_in);
      sck_out <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      sck_out <= 1'b0;
    end
    sda_out <= ~b[0];
    repeat (3) @(posedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

// ---- verification/ldrs_core_assertions.sv ----
/*
  Port checker for the scan core, bound to ldrs_core.
  Assumes one clock domain and async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ldrs_core_assertions (
  input wire logic         ref_clk_in,
  input wire logic         rst_in,
  input wire logic         hw_reset_n_pin_in,
  input wire logic         byte_valid_in,
  input wire logic         byte_is_data_in,
  input wire logic [7:0]   byte_in,
  input wire logic         data_read_in,
  input wire logic         cmd_start_in,
  input wire logic         cmd_bias_in,
  input wire logic         cmd_mux_in,
  input wire logic [7:0]   col_addr_out,
  input wire logic [5:0]   start_line_out,
  input wire logic [2:0]   bias_out,
  input wire logic [6:0]   mux_out,
  input wire logic         display_on_out,
  input wire logic         rmw_out,
  input wire logic         frame_shift_clock_out,
  input wire logic [196:0] latch_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] pin_hist_q;
  logic [7:0] gap_q;
  logic       seen_q;
  // Pin reset acts late, so requests count only once it settled
  wire        pin_ok = (&pin_hist_q) & hw_reset_n_pin_in;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_hist_q <= 4'h0;
    end else begin
      pin_hist_q <= {pin_hist_q[2:0], hw_reset_n_pin_in};
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q <= frame_shift_clock_out ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
      seen_q <= pin_ok & (seen_q | frame_shift_clock_out);
    end
  end
  sequence s_data;
    byte_valid_in && byte_is_data_in && pin_ok;
  endsequence
  sequence s_cmd;
    byte_valid_in && !byte_is_data_in && pin_ok;
  endsequence
  a_reset_state: assert property (disable iff (1'b0)
    rst_in ##1 rst_in |-> col_addr_out == 8'h00 && start_line_out == 6'h00
      && bias_out == 3'h5 && mux_out == 7'h40 && !rmw_out)
    else $error("reset state wrong");
  a_col_step: assert property (s_data |=> col_addr_out ==
    (($past(col_addr_out) == 8'h83) ? 8'h00 : $past(col_addr_out) + 8'h01))
    else $error("column step wrong");
  a_rmw_hold: assert property (data_read_in && rmw_out &&
    !byte_valid_in && pin_ok |=> $stable(col_addr_out))
    else $error("column moved in rmw read");
  a_start_load: assert property (s_cmd ##0 cmd_start_in |=>
    start_line_out == $past(byte_in[5:0]))
    else $error("start line not loaded");
  a_bias_refuse: assert property (s_cmd ##0 cmd_bias_in &&
    byte_in[2:0] > 3'h5 |=> $stable(bias_out))
    else $error("bad bias accepted");
  a_bias_take: assert property (s_cmd ##0 cmd_bias_in &&
    byte_in[2:0] <= 3'h5 |=> bias_out == $past(byte_in[2:0]))
    else $error("bias not taken");
  a_mux_refuse: assert property (s_cmd ##0 cmd_mux_in &&
    (byte_in[6:0] == 7'h00 || byte_in[6:0] > 7'h40) |=> $stable(mux_out))
    else $error("bad mux accepted");
  a_blank_latch: assert property (frame_shift_clock_out &&
    !$past(display_on_out) && !$past(display_on_out, 2) |-> latch_out == '0)
    else $error("latch not blank");
  a_line_period: assert property (frame_shift_clock_out &&
    seen_q |-> gap_q == 8'(ldrs_pkg::LINE_CYCLES - 1))
    else $error("line period wrong");
endmodule
bind ldrs_core ldrs_core_assertions ldrs_core_assertions_inst (
  .ref_clk_in, .rst_in, .hw_reset_n_pin_in, .byte_valid_in,
  .byte_is_data_in, .byte_in, .data_read_in, .cmd_start_in, .cmd_bias_in,
  .cmd_mux_in, .col_addr_out, .start_line_out, .bias_out, .mux_out,
  .display_on_out, .rmw_out, .frame_shift_clock_out, .latch_out);
`default_nettype wire

// ---- verification/lcd_display_ram_scan_core_bench.sv ----
/*
  Self-checking bench for the scan core with a host model.
  Assumes a 100 MHz clock and fixed random seed.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_display_ram_scan_core_bench;
  logic         ref_clk_in, rst_in, rd_pend;
  wire          pin_n, vld, isd, rd, sck, sda;
  wire  [7:0]   byt;
  wire  [15:0]  cmd;
  logic [7:0]   rdd, col, bytes[3], r;
  logic [3:0]   page;
  logic [5:0]   start, con;
  logic [2:0]   pwr, bias;
  logic [1:0]   temp;
  logic [6:0]   mux;
  logic         remap, rev, disp, rmw, stat, tst, fsc, ph, p0;
  logic [7:0]   ser;
  logic [196:0] latch, lvl;
  logic [7:0]   rd_q[$];
  int           num_errors, checked, n;
  ldrs_host_model host_inst (.ref_clk_in(ref_clk_in), .pin_n_out(pin_n),
    .valid_out(vld), .is_data_out(isd), .byte_out(byt), .cmd_out(cmd),
    .read_out(rd), .sck_out(sck), .sda_out(sda));
  ldrs_core ldrs_core_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .hw_reset_n_pin_in(pin_n), .byte_valid_in(vld), .byte_is_data_in(isd),
    .byte_in(byt), .data_read_in(rd), .ser_clk_in(sck), .ser_data_in(sda),
    .cmd_col_lo_in(cmd[0]), .cmd_col_hi_in(cmd[1]), .cmd_page_in(cmd[2]),
    .cmd_start_in(cmd[3]), .cmd_contrast_in(cmd[4]), .cmd_power_in(cmd[5]),
    .cmd_bias_in(cmd[6]), .cmd_temp_in(cmd[7]), .cmd_mux_in(cmd[8]),
    .cmd_seg_remap_in(cmd[9]), .cmd_com_rev_in(cmd[10]),
    .cmd_display_in(cmd[11]), .cmd_rmw_in(cmd[12]), .cmd_rmw_end_in(cmd[13]),
    .cmd_static_in(cmd[14]), .cmd_test_in(cmd[15]), .rd_data_out(rdd),
    .col_addr_out(col), .page_addr_out(page), .start_line_out(start),
    .contrast_out(con), .power_ctrl_out(pwr), .bias_out(bias),
    .temp_comp_out(temp), .mux_out(mux), .seg_remap_out(remap),
    .com_rev_out(rev), .display_on_out(disp), .rmw_out(rmw),
    .static_on_out(stat), .test_on_out(tst), .ser_shift_out(ser),
    .frame_shift_clock_out(fsc), .phase_out(ph), .latch_out(latch),
    .level_set_out(lvl));
  always #5 ref_clk_in = ~ref_clk_in;
  task automatic final_report();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge ref_clk_in) begin
    if (rd_pend === 1'b1) begin
      check("rd_data", rdd, rd_q.pop_front());
    end
    rd_pend <= rd;
  end
  task automatic defaults();
    check("col", col, 8'h00);
    check("page_start", {page, start}, 10'h000);
    check("contrast", con, 6'h20);
    check("power", pwr, 3'h0);
    check("bias", bias, 3'h5);
    check("temp", temp, 2'h0);
    check("mux", mux, 7'h40);
    check("remap", {remap, rev}, 2'h0);
    check("modes", {disp, rmw, stat, tst}, 4'h0);
    check("shift", ser, 8'h00);
  endtask
  task automatic set_col(input logic [7:0] c);
    host_inst.put(1'b0, 1, {4'h0, c[7:4]});
    host_inst.put(1'b0, 0, {4'h0, c[3:0]});
  endtask
  task automatic wait_pulse(input logic any);
    n = 0;
    @(posedge ref_clk_in);
    while (!(fsc === 1'b1 && (any || latch[132] === 1'b1)) && n < 8000) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 8000) begin
      check("timeout", 0, 1);
      final_report();
    end
  endtask
  initial begin
    ref_clk_in = 1'b0;
    rst_in = 1'b1;
    rd_pend = 1'b0;
    r = 8'($urandom(25));
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    defaults();
    for (int i = 0; i < 7; i++) begin
      host_inst.put(1'b0, 6, 8'(i));
      check("bias", bias, i < 6 ? i : 5);
    end
    for (int i = 0; i < 4; i++) begin
      host_inst.put(1'b0, 7, 8'(i));
      check("temp", temp, i);
    end
    for (int i = 0; i < 3; i++) begin
      host_inst.put(1'b0, 8, 8'(i * 65));
      check("mux", mux, i == 2 ? 7'h02 : 7'h40);
    end
    host_inst.put(1'b0, 2, 8'h09);
    host_inst.put(1'b0, 2, 8'h05);
    check("page", page, 4'h5);
    set_col(8'h82);
    foreach (bytes[i]) begin
      bytes[i] = 8'($urandom);
      host_inst.put(1'b1, 0, bytes[i]);
    end
    check("col_wrap", col, 8'h01);
    set_col(8'h82);
    foreach (bytes[i]) rd_q.push_back(bytes[i]);
    foreach (bytes[i]) host_inst.get();
    host_inst.put(1'b0, 12, 8'h00);
    set_col(8'h82);
    repeat (3) rd_q.push_back(bytes[0]);
    repeat (2) host_inst.get();
    check("rmw_col", col, 8'h82);
    host_inst.put(1'b0, 13, 8'h00);
    host_inst.get();
    check("col_inc", col, 8'h83);
    host_inst.put(1'b0, 8, 8'h40);
    host_inst.put(1'b0, 2, 8'h00);
    set_col(8'h00);
    host_inst.put(1'b1, 0, 8'h01);
    set_col(8'h83);
    host_inst.put(1'b1, 0, 8'h00);
    // Cases: remap, reverse, start; expect segment 131 and segment 0
    foreach (bytes[i]) host_inst.put(1'b0, 11, 8'h01);
    for (int i = 0; i < 4; i++) begin
      host_inst.put(1'b0, 9, 8'(i == 1));
      host_inst.put(1'b0, 10, i == 3 ? 8'h08 : 8'h00);
      host_inst.put(1'b0, 3, 8'(i > 1));
      wait_pulse(1'b0);
      check("seg", {latch[131], latch[0]},
        i == 1 ? 2'b10 : {1'b0, i != 2});
      // Common 0 comes last in the reversed frame, so i == 3 keeps the phase
      if (i > 0) check("phase", ph ^ p0, i < 3);
      p0 = ph;
    end
    host_inst.put(1'b0, 11, 8'h00);
    repeat (2) wait_pulse(1'b1);
    check("blank", latch == '0, 1'b1);
    @(posedge ref_clk_in);
    check("level", lvl === {197{ph}}, 1'b1);
    host_inst.ser_byte(r);
    check("serial", ser, r);
    host_inst.put(1'b0, 14, 8'h01);
    host_inst.put(1'b0, 15, 8'h01);
    host_inst.put(1'b0, 5, r);
    check("stat_test_pwr", {stat, tst, pwr}, {2'b11, r[2:0]});
    host_inst.pin_reset();
    defaults();
    host_inst.put(1'b0, 4, r);
    check("contrast", con, r[5:0]);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    defaults();
    final_report();
  end
endmodule
`default_nettype wire
